// ### psp_pkg.sv
`default_nettype none
package psp_pkg;
    localparam logic [7:0] PSP_ADR_DATA  = 8'h08;
    localparam logic [7:0] PSP_ADR_PINS  = 8'h09;
    localparam logic [7:0] PSP_ADR_GATES = 8'h0b;
    localparam logic [7:0] PSP_ADR_FLAGS = 8'h0c;
    localparam logic [7:0] PSP_ADR_DIR   = 8'h88;
    localparam logic [7:0] PSP_ADR_CTRL  = 8'h89;
    localparam logic [7:0] PSP_ADR_EN    = 8'h8c;

    localparam int PSP_B_INFULL  = 7;
    localparam int PSP_B_OUTFULL = 6;
    localparam int PSP_B_OVF     = 5;
    localparam int PSP_B_MODE    = 4;
    localparam int PSP_B_IRQ     = 7;
    localparam int PSP_B_GLOBAL  = 7;
    localparam int PSP_B_PERIPH  = 6;

    localparam int PSP_PIN_RD = 0;
    localparam int PSP_PIN_WR = 1;
    localparam int PSP_PIN_CS = 2;

    localparam logic [2:0] PSP_RST_TRIS  = 3'h7;
    localparam logic [7:0] PSP_RST_DIR   = 8'hff;
    localparam logic [7:0] PSP_RST_EN    = 8'h00;
    localparam logic [1:0] PSP_RST_GATES = 2'h0;
    localparam logic [7:0] PSP_RST_LAT   = 8'h00;
endpackage : psp_pkg
`default_nettype wire

// ### psp_evt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface psp_evt_if;
    logic       rd_active;
    logic       rd_done;
    logic       wr_done;
    logic [7:0] word;
    modport src (output rd_active, output rd_done, output wr_done, output word);
    modport dst (input rd_active, input rd_done, input wr_done, input word);
endinterface : psp_evt_if
`default_nettype wire

// ### psp_strobe.sv
`timescale 1ns/10ps
`default_nettype none
module psp_strobe
    import psp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       en,
    input  wire logic [2:0] ctl_in,
    input  wire logic [7:0] data_in,
    psp_evt_if.src          evt
);
    typedef struct packed {
        logic       rd_act;
        logic       wr_act;
        logic [7:0] word;
    } psp_strobe_st_t;

    psp_strobe_st_t s_q;
    psp_strobe_st_t s_d;
    logic           rd_now;
    logic           wr_now;

    always_comb begin
        // Transfer lives while select and one strobe are low
        rd_now = en & ~ctl_in[PSP_PIN_CS] & ~ctl_in[PSP_PIN_RD];
        wr_now = en & ~ctl_in[PSP_PIN_CS] & ~ctl_in[PSP_PIN_WR];
        s_d = s_q;
        s_d.rd_act = rd_now;
        s_d.wr_act = wr_now;
        // Last word seen while low is the one kept at the rising edge
        if (wr_now) begin
            s_d.word = data_in;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign evt.rd_active = s_q.rd_act;
    assign evt.rd_done   = s_q.rd_act & ~rd_now;
    assign evt.wr_done   = s_q.wr_act & ~wr_now;
    assign evt.word      = s_q.word;
endmodule : psp_strobe
`default_nettype wire

// ### psp_irq.sv
`timescale 1ns/10ps
`default_nettype none
module psp_irq (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic set,
    input  wire logic rd_clr,
    input  wire logic wr,
    input  wire logic wbit,
    input  wire logic enable,
    input  wire logic periph_gate,
    input  wire logic global_gate,
    output logic      flag,
    output logic      irq
);
    typedef struct packed {
        logic flag;
        logic irq;
    } psp_irq_st_t;

    psp_irq_st_t s_q;
    psp_irq_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (rd_clr) begin
            s_d.flag = 1'b0;
        end else if (wr) begin
            s_d.flag = wbit;
        end
        // Set beats any clear in the same cycle
        if (set) begin
            s_d.flag = 1'b1;
        end
        s_d.irq = s_d.flag & enable & periph_gate & global_gate;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag = s_q.flag;
    assign irq  = s_q.irq;

    a_flag_on_event : assert property (@(posedge ref_clk) disable iff (!nrst)
        set |=> flag) else $error("event did not set the flag");
    a_flag_holds : assert property (@(posedge ref_clk) disable iff (!nrst)
        flag && !rd_clr && !wr |=> flag) else $error("flag dropped alone");
    a_irq_gated : assert property (@(posedge ref_clk) disable iff (!nrst)
        irq |-> $past(enable) && $past(periph_gate) && $past(global_gate))
        else $error("irq ungated");
endmodule : psp_irq
`default_nettype wire

// ### psp_top.sv
// Behaviour
// - Mode bit turns data port into slave port
// - External strobes access latches asynchronously; here strobes are sampled on ref_clk
// - Control pins become read, write, select
// - Separate output and input 8-bit latches
// - CPU writes output, reads input, same address
// - Data direction ignored; strobes steer data pins
// - Input full set on write, cleared on read
// - Output full set by CPU, cleared externally
// - Second write sets overflow, keeps old word
// - Full flags held clear outside slave mode
// - Overflow sticky; only software write clears
// - Every external transfer latches interrupt flag
// - Interrupt flag stays until software clears
// - Request only while enable bit set
// - Peripheral and global gates also required
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module psp_top
    import psp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic      [7:0] data_oe,
    input  wire logic [2:0] ctl_in,
    output logic      [2:0] ctl_out,
    output logic      [2:0] ctl_oe,
    output logic            irq
);
    typedef struct packed {
        logic [7:0] out_lat;
        logic [7:0] in_lat;
        logic [2:0] pin_lat;
        logic [7:0] dir;
        logic [7:0] en;
        logic [1:0] gates;
        logic       in_full;
        logic       out_full;
        logic       in_ovf;
        logic       mode;
        logic [2:0] tris;
        logic [7:0] rdata;
        logic [7:0] dout;
        logic [7:0] doe;
        logic [2:0] cout;
        logic [2:0] coe;
    } psp_top_st_t;

    psp_top_st_t s_q;
    psp_top_st_t s_d;

    psp_evt_if evt ();

    logic       wr_data;
    logic       rd_data;
    logic       wr_ctrl;
    logic       wr_pins;
    logic       wr_dir;
    logic       wr_en;
    logic       wr_gates;
    logic       wr_flags;
    logic       rd_flags;
    logic       irq_flag;
    logic       irq_out;
    logic [7:0] rd_mux;

    assign wr_data  = reg_wr && (reg_addr == PSP_ADR_DATA);
    assign rd_data  = reg_rd && (reg_addr == PSP_ADR_DATA);
    assign wr_ctrl  = reg_wr && (reg_addr == PSP_ADR_CTRL);
    assign wr_pins  = reg_wr && (reg_addr == PSP_ADR_PINS);
    assign wr_dir   = reg_wr && (reg_addr == PSP_ADR_DIR);
    assign wr_en    = reg_wr && (reg_addr == PSP_ADR_EN);
    assign wr_gates = reg_wr && (reg_addr == PSP_ADR_GATES);
    assign wr_flags = reg_wr && (reg_addr == PSP_ADR_FLAGS);
    assign rd_flags = reg_rd && (reg_addr == PSP_ADR_FLAGS);

    // Strobe tracking only runs in slave mode
    psp_strobe u_strobe (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .en      (s_q.mode),
        .ctl_in  (ctl_in),
        .data_in (data_in),
        .evt     (evt)
    );

    psp_irq u_irq (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .set         (evt.rd_done | evt.wr_done),
        .rd_clr      (rd_flags),
        .wr          (wr_flags),
        .wbit        (reg_wdata[PSP_B_IRQ]),
        .enable      (s_q.en[PSP_B_IRQ]),
        .periph_gate (s_q.gates[0]),
        .global_gate (s_q.gates[1]),
        .flag        (irq_flag),
        .irq         (irq_out)
    );

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            PSP_ADR_DATA: begin
                // Slave mode reads the input latch, port mode the pins
                rd_mux = s_q.mode ? s_q.in_lat : data_in;
            end
            PSP_ADR_PINS: begin
                rd_mux = {5'h00, ctl_in};
            end
            PSP_ADR_GATES: begin
                rd_mux = {s_q.gates[1], s_q.gates[0], 6'h00};
            end
            PSP_ADR_FLAGS: begin
                rd_mux = {irq_flag, 7'h00};
            end
            PSP_ADR_DIR: begin
                rd_mux = s_q.dir;
            end
            PSP_ADR_CTRL: begin
                rd_mux = {s_q.in_full, s_q.out_full, s_q.in_ovf, s_q.mode, 1'b0, s_q.tris};
            end
            PSP_ADR_EN: begin
                rd_mux = {s_q.en[PSP_B_IRQ], 7'h00};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.rdata = reg_rd ? rd_mux : 8'h00;

        if (wr_data) begin
            s_d.out_lat = reg_wdata;
        end
        if (wr_pins) begin
            s_d.pin_lat = reg_wdata[2:0];
        end
        if (wr_dir) begin
            s_d.dir = reg_wdata;
        end
        if (wr_en) begin
            s_d.en = {reg_wdata[PSP_B_IRQ], 7'h00};
        end
        if (wr_gates) begin
            s_d.gates = {reg_wdata[PSP_B_GLOBAL], reg_wdata[PSP_B_PERIPH]};
        end
        if (wr_ctrl) begin
            s_d.mode = reg_wdata[PSP_B_MODE];
            s_d.tris = reg_wdata[2:0];
            // Writing a zero is the only way out of overflow
            s_d.in_ovf = s_q.in_ovf & reg_wdata[PSP_B_OVF];
        end

        // CPU read empties the input side
        if (rd_data && s_q.mode) begin
            s_d.in_full = 1'b0;
        end
        // External read empties the output side
        if (evt.rd_done) begin
            s_d.out_full = 1'b0;
        end
        // CPU write fills it; wins over a same-cycle external read
        if (wr_data && s_q.mode) begin
            s_d.out_full = 1'b1;
        end

        if (evt.wr_done) begin
            if (s_q.in_full && !rd_data) begin
                s_d.in_ovf = 1'b1;
            end else begin
                s_d.in_lat  = evt.word;
                s_d.in_full = 1'b1;
            end
        end

        if (!s_d.mode) begin
            s_d.in_full  = 1'b0;
            s_d.out_full = 1'b0;
        end

        if (s_d.mode) begin
            // Direction register has no say here
            s_d.dout = s_d.out_lat;
            s_d.doe  = {8{evt.rd_active}};
            s_d.coe  = 3'h0;
        end else begin
            s_d.dout = s_d.out_lat;
            s_d.doe  = ~s_d.dir;
            s_d.coe  = ~s_d.tris;
        end
        s_d.cout = s_d.pin_lat;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q         <= '0;
            s_q.dir     <= PSP_RST_DIR;
            s_q.tris    <= PSP_RST_TRIS;
            s_q.en      <= PSP_RST_EN;
            s_q.gates   <= PSP_RST_GATES;
            s_q.out_lat <= PSP_RST_LAT;
            s_q.in_lat  <= PSP_RST_LAT;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign data_out  = s_q.dout;
    assign data_oe   = s_q.doe;
    assign ctl_out   = s_q.cout;
    assign ctl_oe    = s_q.coe;
    assign irq       = irq_out;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_ext_write_full;
        s_q.mode && evt.wr_done && s_q.in_full && !rd_data && !wr_ctrl;
    endsequence

    sequence s_ext_write_empty;
        s_q.mode && evt.wr_done && !s_q.in_full && !wr_ctrl;
    endsequence

    sequence s_cpu_read_in;
        s_q.mode && rd_data && !evt.wr_done && !wr_ctrl;
    endsequence

    sequence s_ext_read_strobe;
        s_q.mode && !wr_ctrl && !ctl_in[PSP_PIN_CS] && !ctl_in[PSP_PIN_RD];
    endsequence

    sequence s_ext_write_strobe;
        s_q.mode && !wr_ctrl && !ctl_in[PSP_PIN_CS] && !ctl_in[PSP_PIN_WR];
    endsequence

    // Strobe or select back high ends the transfer
    sequence s_ext_read_end;
        s_q.mode && !wr_ctrl && !wr_data && (ctl_in[PSP_PIN_CS] || ctl_in[PSP_PIN_RD]);
    endsequence

    sequence s_ext_write_end;
        s_q.mode && !wr_ctrl && (ctl_in[PSP_PIN_CS] || ctl_in[PSP_PIN_WR]);
    endsequence

    a_infull_on_write : assert property (
        s_ext_write_empty |=> s_q.in_full && s_q.in_lat == $past(evt.word))
        else $error("input word not taken");

    a_infull_on_read : assert property (
        s_cpu_read_in |=> !s_q.in_full)
        else $error("input full not cleared by read");

    a_outfull_on_cpu : assert property (
        s_q.mode && wr_data && !wr_ctrl |=> s_q.out_full && s_q.out_lat == $past(reg_wdata))
        else $error("output full not set");

    a_outfull_on_ext : assert property (
        evt.rd_done && !wr_data |=> !s_q.out_full)
        else $error("output full not cleared");

    a_ovf_keeps_word : assert property (
        s_ext_write_full |=> s_q.in_ovf && $stable(s_q.in_lat))
        else $error("overflow lost or word overwritten");

    a_flags_off_mode : assert property (
        !s_q.mode |-> !s_q.in_full && !s_q.out_full)
        else $error("full flag outside slave mode");

    a_ovf_sticky : assert property (
        s_q.in_ovf && !wr_ctrl |=> s_q.in_ovf)
        else $error("overflow cleared without write");

    a_pins_follow : assert property (
        s_ext_read_strobe ##1 (s_q.mode && !wr_ctrl)
        |=> data_oe == 8'hff && data_out == s_q.out_lat)
        else $error("data pins not driven on read strobe");

    a_no_drive_idle : assert property (
        (s_q.mode && ctl_in[PSP_PIN_RD] && !wr_ctrl)
        ##1 (s_q.mode && ctl_in[PSP_PIN_RD] && !wr_ctrl) |=> data_oe == 8'h00)
        else $error("data pins driven without read strobe");

    a_read_one_cycle : assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");

    a_read_completes : assert property (
        s_ext_read_strobe ##1 s_ext_read_end |=> !s_q.out_full && irq_flag)
        else $error("external read did not complete");

    a_write_completes : assert property (
        s_ext_write_strobe ##1 s_ext_write_end |=> s_q.in_full && irq_flag)
        else $error("external write did not complete");

    a_irq_follows : assert property (
        irq_flag && s_q.en[PSP_B_IRQ] && s_q.gates == 2'h3 && !rd_flags && !wr_flags |=> irq)
        else $error("enabled flag raised no request");

    a_ovf_write_clr : assert property (
        wr_ctrl && !reg_wdata[PSP_B_OVF] && !evt.wr_done |=> !s_q.in_ovf)
        else $error("overflow not cleared by write");

    a_ovf_write_one : assert property (
        wr_ctrl && !s_q.in_ovf && !evt.wr_done |=> !s_q.in_ovf)
        else $error("overflow set by software");

    a_ctl_inputs_mode : assert property (
        s_q.mode |-> ctl_oe == 3'h0)
        else $error("control pins driven in slave mode");

    a_gpio_dir : assert property (
        !s_q.mode |-> data_oe == ~s_q.dir)
        else $error("data enables ignore direction");

    a_in_word_read : assert property (
        s_q.mode && rd_data |=> reg_rdata == $past(s_q.in_lat))
        else $error("data read missed input latch");

    a_strobes_ignored : assert property (
        !s_q.mode |=> !evt.rd_done && !evt.wr_done)
        else $error("transfer seen outside slave mode");

    a_out_lat_hold : assert property (
        !wr_data |=> $stable(s_q.out_lat))
        else $error("output latch changed without write");

    a_pins_latch : assert property (
        wr_pins |=> ctl_out == $past(reg_wdata[2:0]))
        else $error("control pin latch not written");
endmodule : psp_top
`default_nettype wire

// ### psp_ext_master.sv
`timescale 1ns/10ps
`default_nettype none
module psp_ext_master (
    input  wire logic       ref_clk,
    input  wire logic [7:0] dq_seen,
    output logic      [2:0] ctl,
    output logic      [7:0] dq_drv
);
    initial begin
        ctl    = 3'h7;
        dq_drv = 8'h00;
    end

    // Select and write strobe low together, rising edge completes
    task automatic ext_write(input logic [7:0] w);
        @(posedge ref_clk);
        ctl    <= 3'h1;
        dq_drv <= w;
        repeat (2) @(posedge ref_clk);
        ctl <= 3'h7;
        @(posedge ref_clk);
        // Released bus shows inverted data, never a stale copy
        dq_drv <= ~w;
        repeat (2) @(posedge ref_clk);
    endtask : ext_write

    // Select and read strobe low together; data sampled before release
    task automatic ext_read(output logic [7:0] r);
        @(posedge ref_clk);
        ctl <= 3'h2;
        repeat (4) @(posedge ref_clk);
        r = dq_seen;
        ctl <= 3'h7;
        repeat (3) @(posedge ref_clk);
    endtask : ext_read
endmodule : psp_ext_master
`default_nettype wire

// ### tb_parallel_slave_port.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb_parallel_slave_port
    import psp_pkg::*;
();
    logic       ref_clk;
    logic       nrst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] data_out;
    logic [7:0] data_oe;
    logic [2:0] ctl_out;
    logic [2:0] ctl_oe;
    logic       irq;
    logic [2:0] mst_ctl;
    logic [7:0] mst_dq;
    logic [7:0] bus_dq;
    logic [2:0] bus_ctl;
    logic [7:0] got;
    int         n_errors;
    int         comparisons;

    // Whoever enables a bit owns that wire
    assign bus_dq  = (data_oe & data_out) | (~data_oe & mst_dq);
    assign bus_ctl = (ctl_oe & ctl_out) | (~ctl_oe & mst_ctl);

    psp_top dut_u (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .data_in   (bus_dq),
        .data_out  (data_out),
        .data_oe   (data_oe),
        .ctl_in    (bus_ctl),
        .ctl_out   (ctl_out),
        .ctl_oe    (ctl_oe),
        .irq       (irq)
    );

    psp_ext_master mst_u (
        .ref_clk (ref_clk),
        .dq_seen (bus_dq),
        .ctl     (mst_ctl),
        .dq_drv  (mst_dq)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        `CHK(nm, exp, reg_rdata)
    endtask : reg_check

    task automatic test_end(input string nm);
        $display("test %s done, errors so far %0d", nm, n_errors);
    endtask : test_end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    initial begin
        ref_clk   = 1'b0;
        nrst      = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        reg_check(PSP_ADR_CTRL, 8'h07, "ctrl reset");
        reg_check(PSP_ADR_FLAGS, 8'h00, "flags reset");
        reg_check(PSP_ADR_EN, 8'h00, "enables reset");
        reg_check(8'h55, 8'h00, "unmapped");
        test_end("reset");

        reg_write(PSP_ADR_DIR, 8'h00);
        reg_write(PSP_ADR_CTRL, 8'h10);
        repeat (3) @(posedge ref_clk);
        `CHK("ctl enables", 3'h0, ctl_oe)
        `CHK("data enables", 8'h00, data_oe)
        reg_write(PSP_ADR_CTRL, 8'h17);
        reg_write(PSP_ADR_EN, 8'h80);
        reg_write(PSP_ADR_GATES, 8'hc0);
        reg_write(PSP_ADR_DATA, 8'ha5);
        reg_check(PSP_ADR_CTRL, 8'h57, "output full set");
        mst_u.ext_read(got);
        `CHK("external read", 8'ha5, got)
        reg_check(PSP_ADR_CTRL, 8'h17, "output full clear");
        `CHK("irq after read", 1'b1, irq)
        repeat (10) @(posedge ref_clk);
        reg_check(PSP_ADR_FLAGS, 8'h80, "flag held");
        reg_check(PSP_ADR_FLAGS, 8'h00, "flag cleared");
        test_end("cpu to master");

        mst_u.ext_write(8'h3c);
        reg_check(PSP_ADR_CTRL, 8'h97, "input full");
        mst_u.ext_write(8'hc3);
        reg_check(PSP_ADR_CTRL, 8'hb7, "overflow");
        reg_check(PSP_ADR_DATA, 8'h3c, "first word kept");
        reg_check(PSP_ADR_CTRL, 8'h37, "input read");
        reg_check(PSP_ADR_FLAGS, 8'h80, "flag on write");
        test_end("master to cpu");

        reg_write(PSP_ADR_EN, 8'h00);
        mst_u.ext_write(8'h11);
        `CHK("irq masked", 1'b0, irq)
        reg_write(PSP_ADR_EN, 8'h80);
        repeat (3) @(posedge ref_clk);
        `CHK("irq unmasked", 1'b1, irq)
        reg_write(PSP_ADR_GATES, 8'h80);
        repeat (3) @(posedge ref_clk);
        `CHK("irq periph gate", 1'b0, irq)
        reg_write(PSP_ADR_GATES, 8'h40);
        repeat (3) @(posedge ref_clk);
        `CHK("irq global gate", 1'b0, irq)
        reg_write(PSP_ADR_GATES, 8'hc0);
        reg_check(PSP_ADR_FLAGS, 8'h80, "flag masked set");
        repeat (2) @(posedge ref_clk);
        `CHK("irq after clear", 1'b0, irq)
        reg_write(PSP_ADR_FLAGS, 8'h80);
        repeat (2) @(posedge ref_clk);
        `CHK("irq soft set", 1'b1, irq)
        reg_write(PSP_ADR_FLAGS, 8'h00);
        repeat (2) @(posedge ref_clk);
        `CHK("irq soft clear", 1'b0, irq)
        test_end("interrupt");

        reg_write(PSP_ADR_CTRL, 8'h27);
        reg_check(PSP_ADR_CTRL, 8'h27, "mode off flags");
        `CHK("gpio data enables", 8'hff, data_oe)
        mst_u.ext_write(8'h99);
        reg_check(PSP_ADR_FLAGS, 8'h00, "strobes ignored");
        reg_write(PSP_ADR_CTRL, 8'h07);
        reg_check(PSP_ADR_CTRL, 8'h07, "overflow cleared");
        reg_write(PSP_ADR_PINS, 8'h05);
        reg_write(PSP_ADR_CTRL, 8'h20);
        repeat (2) @(posedge ref_clk);
        `CHK("ctl pin enables", 3'h7, ctl_oe)
        `CHK("ctl pin levels", 3'h5, ctl_out)
        `CHK("gpio data out", 8'ha5, data_out)
        reg_check(PSP_ADR_CTRL, 8'h00, "overflow not set by one");
        reg_check(PSP_ADR_PINS, 8'h05, "ctl pins read");
        reg_check(PSP_ADR_DATA, 8'ha5, "gpio pins read");
        reg_check(PSP_ADR_DIR, 8'h00, "direction read");
        reg_check(PSP_ADR_GATES, 8'hc0, "gates read");
        test_end("mode off");
        print_verdict();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end
endmodule : tb_parallel_slave_port
`default_nettype wire
